// ===== design/sdram_local_port_resync.v
/*
 Local request port and read-data resynchroniser of a ddr sdram controller.
 Assumes: memory-side sequencer takes the command outputs and answers
 with cmd_done; read data arrives captured on resync_clk (may be mclk).
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdram_front_consts.vh"

// Behaviour
// - captured read data crosses via registers clocked by resync clock.
// - edge select high enables falling-edge register pair after resync regs.
// - mux on edge select picks rising or falling path into system register.
// - edge select low bypasses falling pair; resync feeds system register.
// - address width is bank+row+col-1, plus chip bits for multiple selects.
// - memory column lsb is not on the local address; it is zero.
// - local address decodes as chip, bank, row, column from msb down.
// - write bytes with byte enable low are masked, not written.
// - burst begin marks first burst cycle; only in burst mode, length>2.
// - consecutive user refresh requests give back-to-back refreshes.
// - dll reference clock is gated off during reads.
// - read/write requests are taken only while ready is high.
// - refresh acknowledge pulses one cycle per issued refresh.
module sdram_local_port_resync #(
  parameter BANK_BITS = `BANK_BITS,
  parameter ROW_BITS = `ROW_BITS,
  parameter COL_BITS = `COL_BITS,
  parameter CHIP_BITS = `CHIP_BITS,
  parameter MULTI_CS = 1,
  parameter DQ_BITS = `MEM_DQ_BITS,
  parameter BURST_LEN = `MEM_BURST_LEN,
  parameter BURST_MODE = 1,
  parameter AUTO_REF_CYCLES = `AUTO_REF_CYCLES,
  parameter AW = (MULTI_CS ? CHIP_BITS : 0) + BANK_BITS + ROW_BITS
                 + COL_BITS - 1,
  parameter LW = 2 * DQ_BITS,
  parameter BW = LW / 8
) (
  // clocks and reset
  input wire mclk,
  input wire resync_clk,
  input wire reset,
  // configuration
  input wire user_refresh_en,
  input wire resync_edge_select,
  // local request port
  input wire [AW-1:0] host_addr,
  input wire [BW-1:0] host_byte_enables,
  input wire [LW-1:0] host_wdata,
  input wire host_burstbegin,
  input wire host_read_req,
  input wire host_write_req,
  input wire host_refresh_req,
  output wire host_ready,
  output reg host_refresh_ack,
  output reg [LW-1:0] host_rdata,
  output reg host_rdata_valid,
  // toward the memory sequencer
  output reg [1:0] cmd_r,
  output reg [CHIP_BITS-1:0] cmd_chip,
  output reg [BANK_BITS-1:0] cmd_bank,
  output reg [ROW_BITS-1:0] cmd_row,
  output reg [COL_BITS-1:0] cmd_col,
  output reg [LW-1:0] cmd_wdata,
  output reg [BW-1:0] cmd_dm,
  output reg cmd_burst_first,
  input wire cmd_done,
  output reg dll_ref_disable,
  // captured read data, resync_clk domain
  input wire [LW-1:0] cap_data,
  input wire cap_valid
);
  localparam ST_IDLE = `ST_IDLE;
  localparam ST_BUSY = `ST_BUSY;
  localparam ST_REF = `ST_REF;
  localparam RW = 24;
  localparam CHIP_LO = BANK_BITS + ROW_BITS + COL_BITS - 1;

  // edge select and refresh request come from outside: two flops each
  reg sel_s1_r, sel_s2_r;
  reg ref_s1_r, ref_s2_r;
  reg [2:0] state_r, state_nxt;
  reg [RW-1:0] ref_cnt_r;
  reg auto_pend_r;
  wire ref_pend;
  wire take_rw;

  always @(posedge mclk) begin
    sel_s1_r <= resync_edge_select;
    sel_s2_r <= sel_s1_r;
    ref_s1_r <= host_refresh_req;
    ref_s2_r <= ref_s1_r;
  end

  // is met by the synchronous reset itself
  // user refresh wins over automatic counter when enabled
  assign ref_pend = user_refresh_en ? ref_s2_r : auto_pend_r;
  // ready drops while a refresh waits, so refresh goes first
  assign host_ready = (state_r == ST_IDLE) && !ref_pend;
  assign take_rw = host_ready && (host_read_req || host_write_req);

  always @(posedge mclk) begin
    if (reset || user_refresh_en) begin
      ref_cnt_r <= {RW{1'b0}};
      auto_pend_r <= 1'b0;
    end else if (state_r == ST_REF) begin
      auto_pend_r <= 1'b0;
    end else if (ref_cnt_r == AUTO_REF_CYCLES - 1) begin
      ref_cnt_r <= {RW{1'b0}};
      auto_pend_r <= 1'b1;
    end else begin
      ref_cnt_r <= ref_cnt_r + {{(RW-1){1'b0}}, 1'b1};
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (ref_pend)
          state_nxt = ST_REF;
        else if (take_rw)
          state_nxt = ST_BUSY;
      end
      ST_BUSY: begin
        if (cmd_done)
          state_nxt = ST_IDLE;
      end
      ST_REF: begin
        // back to idle on done; a still-held request refreshes again from idle
        if (cmd_done)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cmd_r <= `CMD_NONE;
      cmd_chip <= {CHIP_BITS{1'b0}};
      cmd_bank <= {BANK_BITS{1'b0}};
      cmd_row <= {ROW_BITS{1'b0}};
      cmd_col <= {COL_BITS{1'b0}};
      cmd_wdata <= {LW{1'b0}};
      cmd_dm <= {BW{1'b0}};
      cmd_burst_first <= 1'b0;
      host_refresh_ack <= 1'b0;
      dll_ref_disable <= 1'b0;
    end else begin
      state_r <= state_nxt;
      host_refresh_ack <= 1'b0;
      if (state_r == ST_IDLE && ref_pend) begin
        cmd_r <= `CMD_REFRESH;
        host_refresh_ack <= 1'b1;
      end else if (take_rw) begin
        cmd_r <= host_read_req ? `CMD_READ : `CMD_WRITE;
        dll_ref_disable <= host_read_req;
        // chip, bank, row, column from msb down
        cmd_chip <= MULTI_CS ? host_addr[AW-1 -: CHIP_BITS]
                             : {CHIP_BITS{1'b0}};
        cmd_bank <= host_addr[CHIP_LO-1 -: BANK_BITS];
        cmd_row <= host_addr[COL_BITS+ROW_BITS-2 -: ROW_BITS];
        // column lsb is implicit zero
        cmd_col <= {host_addr[COL_BITS-2:0], 1'b0};
        cmd_wdata <= host_wdata;
        cmd_dm <= ~host_byte_enables;
        // burst strobe only honoured where it exists
        cmd_burst_first <= (BURST_MODE != 0) && (BURST_LEN > 2)
                           && host_burstbegin;
      end else if (cmd_done) begin
        cmd_r <= `CMD_NONE;
        dll_ref_disable <= 1'b0;
        cmd_burst_first <= 1'b0;
      end
    end
  end

  // read path: resync regs on rising resync edge
  reg [LW-1:0] rs_data_r;
  reg rs_valid_r;
  reg [LW-1:0] fe_data_r;
  reg fe_valid_r;
  always @(posedge resync_clk) begin
    rs_data_r <= cap_data;
    rs_valid_r <= cap_valid;
  end
  // select gets its own two flops in the resync domain
  reg sel_rs1_r, sel_rs2_r;
  always @(posedge resync_clk) begin
    sel_rs1_r <= resync_edge_select;
    sel_rs2_r <= sel_rs1_r;
  end
  // falling pair loads only when selected
  always @(negedge resync_clk) begin
    if (sel_rs2_r) begin
      fe_data_r <= rs_data_r;
      fe_valid_r <= rs_valid_r;
    end
  end

  // select picks falling path or bypass into mclk register
  always @(posedge mclk) begin
    if (reset) begin
      host_rdata <= {LW{1'b0}};
      host_rdata_valid <= 1'b0;
    end else begin
      host_rdata <= sel_s2_r ? fe_data_r : rs_data_r;
      host_rdata_valid <= sel_s2_r ? fe_valid_r : rs_valid_r;
    end
  end
endmodule
`default_nettype wire

// ===== include/sdram_front_consts.vh
/*
 Constants for the sdram local port and read resynchroniser.
 Assumes inclusion by bare name from design files.
*/
`ifndef SDRAM_FRONT_CONSTS_VH
`define SDRAM_FRONT_CONSTS_VH
`define BANK_BITS 2
`define ROW_BITS 13
`define COL_BITS 10
`define CHIP_BITS 1
`define MEM_DQ_BITS 16
`define MEM_BURST_LEN 4
`define CMD_NONE 2'h0
`define CMD_READ 2'h1
`define CMD_WRITE 2'h2
`define CMD_REFRESH 2'h3
`define ST_IDLE 3'h1
`define ST_BUSY 3'h2
`define ST_REF 3'h4
`define AUTO_REF_TIME_NS 7800
`define CLK_PERIOD_NS 10
`define AUTO_REF_CYCLES (`AUTO_REF_TIME_NS / `CLK_PERIOD_NS)
`define ACCESS_CYCLES 4
`endif

// ===== verif/sdram_front_checker.sv
/* port checker for the local request front end.
 assumes one clock, sync reset, bound to the top. */
`timescale 1ns/1ps
`default_nettype none
module sdram_front_checker (
  // clock, reset
  input wire logic mclk,
  input wire logic reset,
  // watched ports
  input wire logic host_ready,
  input wire logic host_read_req,
  input wire logic host_write_req,
  input wire logic host_refresh_ack,
  input wire logic [1:0] cmd_r,
  input wire logic cmd_done,
  input wire logic dll_ref_disable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_take_rd;
    host_ready && host_read_req;
  endsequence
  sequence s_finish;
    cmd_r != 2'h0 && cmd_done;
  endsequence
  a_read_taken: assert property (s_take_rd |=> cmd_r == 2'h1)
    else $error("read not issued");
  a_write_taken: assert property (host_ready && host_write_req
    && !host_read_req |=> cmd_r == 2'h2) else $error("write not issued");
  a_busy_blocks: assert property (cmd_r != 2'h0 |-> !host_ready)
    else $error("ready while busy");
  a_cmd_held: assert property (cmd_r != 2'h0 && !cmd_done
    |=> $stable(cmd_r)) else $error("command dropped early");
  a_done_ends: assert property (s_finish |=> cmd_r == 2'h0)
    else $error("command not released");
  a_ack_single: assert property (host_refresh_ack
    |=> !host_refresh_ack) else $error("ack longer than one cycle");
  a_ack_with_ref: assert property (host_refresh_ack
    |-> cmd_r == 2'h3) else $error("ack without refresh");
  a_dll_gated: assert property (cmd_r == 2'h1 |-> dll_ref_disable)
    else $error("dll clock not gated");
endmodule
`default_nettype wire

// ===== verif/seq_model.sv
/* memory sequencer model answering commands.
 assumes cmd_r holds until one cmd_done pulse. */
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  // clock, reset
  input wire logic mclk,
  input wire logic reset,
  // command handshake
  input wire logic [1:0] cmd_r,
  input wire logic slow,
  output logic cmd_done
);
  logic [2:0] cnt_r;
  // done clears the count so one command gets exactly one pulse
  always @(posedge mclk) begin
    cmd_done <= 1'b0;
    if (reset || cmd_r == 2'h0 || cmd_done) cnt_r <= 3'h0;
    else if (cnt_r == (slow ? 3'h5 : 3'h1)) begin
      cmd_done <= 1'b1;
      cnt_r <= 3'h0;
    end else cnt_r <= cnt_r + 3'h1;
  end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
/* bench: local port, refresh and read resync.
 needs seq_model; resync clock runs 2 ns ahead of mclk. */
`timescale 1ns/1ps
`default_nettype none
`define C(s,e,a) begin comparisons++; if ((a)!==(e)) begin num_errors++; \
 $display("MISMATCH %s exp %h got %h",s,e,a); end end
module testbench;
  logic mclk=0, reset=1, urf=1, es=0, rd=0, wr=0, rf=0, cv=0, slow=0;
  logic [24:0] ad=0;
  logic [3:0] be=0;
  logic [31:0] wd=0, cd=0;
  wire rdy, ack, rv, done, dll, bf, ch, rclk;
  wire [1:0] cmd, bk;
  wire [3:0] dm;
  wire [9:0] col;
  wire [12:0] row;
  wire [31:0] rdat, cwd;
  int num_errors=0, comparisons=0, cyc=0, n, k;
  initial forever #5 mclk = ~mclk;
  // shifted resync clock so the falling pair costs one extra mclk cycle
  assign #3 rclk = ~mclk;
  always @(posedge mclk) if (++cyc == 3000) begin num_errors++; results; end
  sdram_local_port_resync #(.AUTO_REF_CYCLES(20)) u_dut (.mclk(mclk),
    .resync_clk(rclk), .reset(reset), .user_refresh_en(urf),
    .resync_edge_select(es), .host_addr(ad), .host_byte_enables(be),
    .host_wdata(wd), .host_burstbegin(rd | wr), .host_read_req(rd),
    .host_write_req(wr), .host_refresh_req(rf), .host_ready(rdy),
    .host_refresh_ack(ack), .host_rdata(rdat), .host_rdata_valid(rv),
    .cmd_r(cmd), .cmd_chip(ch), .cmd_bank(bk), .cmd_row(row), .cmd_col(col),
    .cmd_wdata(cwd), .cmd_dm(dm), .cmd_burst_first(bf), .cmd_done(done),
    .dll_ref_disable(dll), .cap_data(cd), .cap_valid(cv));
  seq_model u_seq (.mclk(mclk), .reset(reset), .cmd_r(cmd), .slow(slow),
    .cmd_done(done));
  task automatic go(logic r, logic w);
    n = 0;
    while (rdy !== 1'b1 && n < 50) begin @(negedge mclk); n++; end
    `C("rdy", 1'b1, rdy)
    rd = r;
    wr = w;
    @(negedge mclk);
    rd = 0;
    wr = 0;
  endtask
  task automatic refs(logic r, int lim, int want);
    rf = r;
    k = 0;
    n = 0;
    while (k < want && n < lim) begin
      @(negedge mclk);
      n++;
      if (ack === 1'b1) k++;
    end
    rf = 0;
  endtask
  task automatic cap(logic [31:0] v, int lat);
    cd = v;
    cv = 1;
    @(negedge mclk);
    cv = 0;
    cd = ~v;
    n = 0;
    while (rv !== 1'b1 && n < 8) begin @(negedge mclk); n++; end
    `C("rdata", v, rdat)
    `C("lat", lat, n)
  endtask
  task automatic results;
    $display("errors %0d of %0d checks", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    reset = 0;
    ad = {1'b1, 2'h2, 13'h0abc, 9'h155};
    be = 4'h5;
    wd = 32'hcafe0123;
    `C("aw", 32'h19, $bits(u_dut.host_addr))
    go(0, 1);
    `C("cmd", 2'h2, cmd)
    `C("adr", {1'b1,2'h2,13'h0abc,10'h2aa}, {ch,bk,row,col})
    `C("dm", 4'ha, dm)
    `C("wd", wd, cwd)
    `C("bb", 1'b1, bf)
    `C("dll0", 1'b0, dll)
    go(1, 1);
    `C("rd", 2'h1, cmd)
    `C("dll", 1'b1, dll)
    slow = 1;
    go(1, 0);
    wr = 1;
    repeat (3) @(negedge mclk);
    `C("held", 2'h1, cmd)
    wr = 0;
    repeat (9) @(negedge mclk);
    `C("refused", 2'h0, cmd)
    slow = 0;
    cap(32'h1234abcd, 0);
    es = 1;
    repeat (4) @(negedge mclk);
    cap(32'h0f0f5a5a, 1);
    refs(0, 60, 1);
    `C("user", 32'h0, k)
    rf = 1;
    repeat (3) @(negedge mclk);
    rd = 1;
    refs(1, 20, 1);
    `C("pri", 2'h3, cmd)
    n = 0;
    while (cmd !== 2'h1 && n < 20) begin @(negedge mclk); n++; end
    rd = 0;
    `C("then", 2'h1, cmd)
    refs(1, 99, 3);
    `C("b2b", 32'h3, k)
    urf = 0;
    refs(0, 60, 1);
    `C("auto", 32'h1, k)
    results;
  end
endmodule
bind sdram_local_port_resync sdram_front_checker u_chk (.mclk(mclk),
  .reset(reset), .host_ready(host_ready), .host_read_req(host_read_req),
  .host_write_req(host_write_req), .host_refresh_ack(host_refresh_ack),
  .cmd_r(cmd_r), .cmd_done(cmd_done), .dll_ref_disable(dll_ref_disable));
`default_nettype wire
